// ---- include/asbt_pkg.sv ----
// Package for the asynchronous static memory host controller.
// Assumes a single system clock at 40 MHz; all times are in ns.
package asbt_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // ==========================================================
  // Clock and timing (ns)
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_ACCESS_FAST_NS = 45;   // Read/write cycle and access, fast grade
  localparam int T_ACCESS_SLOW_NS = 55;   // Same, slow grade
  localparam int T_ADDR_WEND_FAST_NS = 35;  // Address valid to write end
  localparam int T_ADDR_WEND_SLOW_NS = 40;
  localparam int T_DATA_SETUP_NS = 25;    // Data setup to write end
  localparam int T_OE_DATA_FAST_NS = 22;  // Output strobe to data valid
  localparam int T_OE_DATA_SLOW_NS = 25;
  localparam int T_RECOVERY_FAST_NS = 45; // Retention exit to first access
  localparam int T_RECOVERY_SLOW_NS = 55;

  // Least times round up to whole cycles
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Slow grade figures are used: they cover the fast grade too
  localparam int CYC_ACCESS = cyc_min(T_ACCESS_SLOW_NS);
  localparam int CYC_WE_LOW = cyc_min(T_ADDR_WEND_SLOW_NS);
  localparam int CYC_DATA_SETUP = cyc_min(T_DATA_SETUP_NS);
  localparam int CYC_RECOVERY = cyc_min(T_RECOVERY_SLOW_NS);
  localparam int CYC_WR_GAP = 1;  // Deselected cycles after a write ends
  localparam int CNT_W = 4;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ASBT_IDLE,
    ASBT_RD,
    ASBT_WR,
    ASBT_WR_END,
    ASBT_GAP,
    ASBT_RET,
    ASBT_RECOVER
  } asbt_state_t;

endpackage

// ---- logic/asbt_cycle_timer.sv ----
// Down counter that times each phase of a bus cycle.
// Assumes the loader gives a count of at least one.
`timescale 1ns/1ps
module asbt_cycle_timer #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ==========================================================
  // Next count: load wins, otherwise count down to zero
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Done when the count reaches the last cycle of the phase
  assign done = (cnt_q == W'(1)) && !load;
endmodule

// ---- logic/asbt_sram_host.sv ----
// Host controller that drives a 128K x 8 asynchronous static memory.
// Assumes the memory pins are sampled and driven on sys_clk; the data
// pins are split into in, out and enable, resolved by the surroundings.
`timescale 1ns/1ps
// Notes on behaviour
// - Chip counts as selected only with low select low and high select high.
// - Write starts when all controls assert; any one released ends it.
// - Data setup and hold are timed to the edge ending the write.
// - Address held stable at least 40 ns before write end.
// - Address may change right at the write-ending edge.
// - Address valid no later than write start.
// - Write data driven at least 25 ns before write end.
// - Write data may be released at the write-ending edge.
// - Chip is deselected before supply drops into retention.
// - Wait at least 55 ns after retention before a new access.
// - Read keeps write strobe high; memory drives while selected and strobed.
// - Host never drives data pins while memory drives them.
module asbt_sram_host
  import asbt_pkg::*;
#(
  parameter int AW = asbt_pkg::ADDR_W,
  parameter int DW = asbt_pkg::DATA_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  // Data retention control
  input wire logic ret_req,
  output logic ret_safe,
  // Memory pins
  output logic [AW-1:0] mem_addr,
  output logic select_active_low_n,
  output logic select_active_high,
  output logic we_n,
  output logic oe_n,
  input wire logic [DW-1:0] mem_dq_in,
  output logic [DW-1:0] mem_dq_out,
  output logic mem_dq_oe
);
  import asbt_pkg::*;

  // ==========================================================
  // State
  asbt_state_t state_q, state_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic rsp_q, rsp_d;
  logic sel_q, sel_d;
  logic we_q, we_d;
  logic oe_q, oe_d;
  logic dq_oe_q, dq_oe_d;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_done;

  // Phase timer shared by every state
  asbt_cycle_timer #(
    .W(CNT_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // Requests are only taken when idle and no retention is pending
  assign req_ready = (state_q == ASBT_IDLE) && !ret_req;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    sel_d = sel_q;
    we_d = we_q;
    oe_d = oe_q;
    dq_oe_d = dq_oe_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_q)
      ASBT_IDLE: begin
        if (ret_req) begin
          sel_d = 1'b0;
          state_d = ASBT_RET;
        end else if (req_valid) begin
          addr_d = req_addr;
          wdata_d = req_wdata;
          sel_d = 1'b1;
          tmr_load = 1'b1;
          if (req_write) begin
            we_d = 1'b1;
            // no contention, output strobe stays high
            oe_d = 1'b0;
            dq_oe_d = 1'b1;
            tmr_val = CNT_W'(CYC_WE_LOW);
            state_d = ASBT_WR;
          end else begin
            we_d = 1'b0;
            oe_d = 1'b1;
            dq_oe_d = 1'b0;
            tmr_val = CNT_W'(CYC_ACCESS);
            state_d = ASBT_RD;
          end
        end
      end
      ASBT_RD: begin
        if (tmr_done) begin
          // Sample after full access time; covers address and strobe delays
          rdata_d = mem_dq_in;
          rsp_d = 1'b1;
          oe_d = 1'b0;
          sel_d = 1'b0;
          state_d = ASBT_IDLE;
        end
      end
      ASBT_WR: begin
        if (tmr_done) begin
          we_d = 1'b0;
          state_d = ASBT_WR_END;
        end
      end
      ASBT_WR_END: begin
        dq_oe_d = 1'b0;
        sel_d = 1'b0;
        rsp_d = 1'b1;
        tmr_load = 1'b1;
        tmr_val = CNT_W'(CYC_WR_GAP);
        state_d = ASBT_GAP;
      end
      ASBT_GAP: begin
        if (tmr_done) begin
          state_d = ASBT_IDLE;
        end
      end
      ASBT_RET: begin
        if (!ret_req) begin
          tmr_load = 1'b1;
          tmr_val = CNT_W'(CYC_RECOVERY);
          state_d = ASBT_RECOVER;
        end
      end
      ASBT_RECOVER: begin
        if (tmr_done) begin
          state_d = ASBT_IDLE;
        end
      end
      default: begin
        state_d = ASBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ASBT_IDLE;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rsp_q <= 1'b0;
      sel_q <= 1'b0;
      we_q <= 1'b0;
      oe_q <= 1'b0;
      dq_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      sel_q <= sel_d;
      we_q <= we_d;
      oe_q <= oe_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  // ==========================================================
  // Pin drive; both selects move together so the combined enable is clean
  // combined enable
  assign select_active_low_n = !sel_q;
  assign select_active_high = sel_q;
  assign we_n = !we_q;
  assign oe_n = !oe_q;
  // full 17-bit address, 8-bit data lanes
  assign mem_addr = addr_q;
  assign mem_dq_out = wdata_q;
  assign mem_dq_oe = dq_oe_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  // Safe to lower supply only once parked and deselected
  assign ret_safe = (state_q == ASBT_RET) && !sel_q;
endmodule

// ---- test/asbt_host_checker.sv ----
// Checker for the static memory host pins and user handshake.
// Assumes it is bound to asbt_sram_host and sees only its ports.
`timescale 1ns/1ps
module asbt_host_checker #(
  parameter int AW = 17,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // User side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [DW-1:0] rsp_rdata,
  input wire logic ret_req,
  input wire logic ret_safe,
  // Memory pins
  input wire logic [AW-1:0] mem_addr,
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [DW-1:0] mem_dq_in,
  input wire logic [DW-1:0] mem_dq_out,
  input wire logic mem_dq_oe
);
  // ==========================================================
  // Pin relations and user handshake
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_sel_pair_opp: assert property (select_active_low_n != select_active_high)
    else $error("select pins not complementary");
  a_no_bus_fight: assert property (mem_dq_oe |-> oe_n)
    else $error("host drives data while output strobe low");
  a_we_in_sel: assert property (!we_n |-> !select_active_low_n && mem_dq_oe && oe_n)
    else $error("write strobe outside a driven selected write");
  a_we_pulse_len: assert property ($fell(we_n) |-> !we_n [*2] ##1 we_n)
    else $error("write strobe width wrong");
  a_wr_hold_stable: assert property (!we_n && !$past(we_n) |-> $stable(mem_addr) && $stable(mem_dq_out))
    else $error("address or data moved inside write");
  a_we_ends_first: assert property ($rose(we_n) |-> !select_active_low_n && mem_dq_oe)
    else $error("write not ended by strobe");
  a_ret_deselect: assert property (ret_safe |-> select_active_low_n && we_n && !mem_dq_oe)
    else $error("selected while parked");
  a_ret_recover: assert property ($fell(ret_safe) |-> select_active_low_n [*3])
    else $error("access too soon after retention");
  a_rd_answer: assert property (req_valid && req_ready && !req_write |-> ##[4:5] rsp_valid)
    else $error("read answer late");
  a_rsp_single: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse too long");
  a_wr_answer: assert property (req_valid && req_ready && req_write |-> ##4 rsp_valid)
    else $error("write answer not on time");
  a_rd_strobe_only: assert property (!oe_n |-> we_n && !select_active_low_n && !mem_dq_oe)
    else $error("output strobe low outside a clean read");
endmodule
bind asbt_sram_host asbt_host_checker #(.AW(AW), .DW(DW)) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req_write(req_write),
  .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_rdata(rsp_rdata), .ret_req(ret_req), .ret_safe(ret_safe), .mem_addr(mem_addr),
  .select_active_low_n(select_active_low_n), .select_active_high(select_active_high),
  .we_n(we_n), .oe_n(oe_n), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

// ---- test/asbt_mem_model.sv ----
// Behavioural model of the clockless byte-wide static memory.
// Assumes the bench resolves the data pins from the host enable mem_dq_oe alone.
`timescale 1ns/1ps
module asbt_mem_model
  import asbt_pkg::*;
(
  // Pins from the host
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [DATA_W-1:0] dq_bus,
  // Byte driven back
  output logic [DATA_W-1:0] mem_q
);
  import asbt_pkg::*;
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last_q = 8'h00;
  logic [ADDR_W-1:0] wr_addr = '0;
  logic [DATA_W-1:0] wr_byte = '0;
  logic ce;
  logic wr;
  logic drv;
  assign ce = !select_active_low_n && select_active_high;
  // write window is the overlap of strobe and enable
  assign wr = ce && !we_n;
  // keep what stands while the window is open; start-of-write glitches cannot hit a cell
  always @* begin
    if (wr) begin
      wr_addr = mem_addr;
      wr_byte = dq_bus;
    end
  end
  // the cell takes the byte at the edge that ends the write
  always @(negedge wr) cells[wr_addr] = wr_byte;
  assign drv = ce && !oe_n && we_n;
  always @* if (drv) last_q = cells[mem_addr];
  // data as late as the slow grade allows; released pins show the inverse so stale reads fail
  assign #(T_ACCESS_SLOW_NS) mem_q = drv ? cells[mem_addr] : ~last_q;
endmodule

// ---- test/asbt_sram_host_tb.sv ----
// Self-checking bench: random writes, read-back, retention park.
// Assumes the memory model stands on the data pins.
`timescale 1ns/1ps
module asbt_sram_host_tb;
  import asbt_pkg::*;
  logic sys_clk, arst_n, req_valid, req_write, req_ready, rsp_valid, ret_req, ret_safe;
  logic sel_n, sel_h, we_n, oe_n, mem_dq_oe;
  logic [ADDR_W-1:0] req_addr, mem_addr, a;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_dq_in, mem_dq_out, mem_q, d, rd;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] addr_q [$];
  int n_errors, cmp_count;
  // Pins carry the host byte while it drives, else the memory
  assign mem_dq_in = mem_dq_oe ? mem_dq_out : mem_q;
  always #12.5 sys_clk = ~sys_clk;
  asbt_sram_host u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .ret_req(ret_req), .ret_safe(ret_safe), .mem_addr(mem_addr),
    .select_active_low_n(sel_n), .select_active_high(sel_h), .we_n(we_n), .oe_n(oe_n),
    .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
  asbt_mem_model u_mem (.mem_addr(mem_addr), .select_active_low_n(sel_n), .select_active_high(sel_h),
    .we_n(we_n), .oe_n(oe_n), .dq_bus(mem_dq_in), .mem_q(mem_q));
  // ==========================================================
  // Checking and verdict
  task automatic check(input string what, input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One request, driven at falling edges; waits are bounded
  task automatic do_op(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
    int n;
    int lat;
    n = 0;
    lat = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = ad;
    req_wdata = wd;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && lat < 20) begin
      @(negedge sys_clk);
      lat++;
    end
    check("answer_lat", 17'(lat), wr ? 17'(CYC_WE_LOW + 1) : 17'(CYC_ACCESS));
    rd = rsp_rdata;
    @(negedge sys_clk);
  endtask
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
  // ==========================================================
  // Main sequence: corners first, then random addresses
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    {req_valid, req_write, ret_req, req_addr, req_wdata} = '0;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(53));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    check("reset_pins", 17'({we_n, oe_n, sel_n, sel_h, mem_dq_oe}), 17'h0001c);
    arst_n = 1'b1;
    for (int i = 0; i < 14; i++) begin
      a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1ffff : 17'($urandom);
      d = 8'($urandom);
      ref_mem[a] = d;
      addr_q.push_back(a);
      do_op(1'b1, a, d);
    end
    foreach (addr_q[i]) begin
      do_op(1'b0, addr_q[i], 8'h00);
      check("read_byte", 17'(rd), 17'(ref_mem[addr_q[i]]));
    end
    ret_req = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("ret_park", 17'({ret_safe, sel_n, req_ready}), 17'h00006);
    ret_req = 1'b0;
    repeat (CYC_RECOVERY) @(negedge sys_clk);
    check("recover_wait", 17'(req_ready), 17'h00000);
    do_op(1'b0, addr_q[1], 8'h00);
    check("after_ret", 17'(rd), 17'(ref_mem[addr_q[1]]));
    print_verdict();
  end
endmodule
